// ### core/nvmp_cfg.svh
// constants for the nonvolatile-memory program control block
// assumes inclusion by the package, the design files and the bench host and top files
`ifndef NVMP_CFG_SVH
`define NVMP_CFG_SVH
`define NVMP_CMD_SETTINGS 8'hBB
`define NVMP_CMD_UNLOCK 8'hB9
`define NVMP_CMD_SLEEP_EXIT 8'h11
`define NVMP_CMD_SW_RESET 8'h01
// unlock key; values arbitrary, a real part holds its own
`define NVMP_KEY0 8'hA5
`define NVMP_KEY1 8'h5A
`define NVMP_KEY2 8'hC3
`define NVMP_BIT_LOAD_DIS 7
`define NVMP_BIT_CHARGE 5
`define NVMP_BIT_WPERMIT 4
`define NVMP_TEST_HI 3
`define NVMP_TEST_LO 1
`define NVMP_BIT_PROG 0
`define NVMP_BIT_READ 0
`define NVMP_RST_BYTE 8'h00
`define NVMP_RST_TEST 3'h0
// a program pulse is 10 us, a read 200 ns
`define NVMP_PROG_NS 10000
`define NVMP_READ_NS 200
`define NVMP_CLK_NS 40
`define NVMP_PROG_CYC ((`NVMP_PROG_NS + `NVMP_CLK_NS - 1) / `NVMP_CLK_NS)
`define NVMP_READ_CYC ((`NVMP_READ_NS + `NVMP_CLK_NS - 1) / `NVMP_CLK_NS)
`define NVMP_CNT_W 9
`define NVMP_DEPTH 256
`endif

// ### core/nvmp_pkg.sv
// types for the nonvolatile-memory program control block
// assumes nvmp_cfg.svh is on the include path
package nvmp_pkg;
  `include "nvmp_cfg.svh"
  typedef struct packed {
    logic load_dis;
    logic charge;
    logic wpermit;
    logic [2:0] test;
    logic prog;
  } nvmp_flags_t;
  typedef struct packed {
    logic busy;
    logic rd_valid;
    logic [7:0] rd_data;
  } nvmp_stat_t;
  typedef enum logic [2:0] {
    NVMP_IDLE, NVMP_P1, NVMP_P2, NVMP_P3, NVMP_P4, NVMP_K1, NVMP_K2, NVMP_K3
  } nvmp_parse_t;
  typedef enum logic [1:0] {NVMP_OP_IDLE, NVMP_OP_PROG, NVMP_OP_READ, NVMP_OP_LOAD} nvmp_op_t;
endpackage : nvmp_pkg

// ### core/nvmp_mem.sv
// nonvolatile table model: 256 bytes with bit-masked programming
// assumes one access per cycle; read data registered
`include "nvmp_cfg.svh"
module nvmp_mem
  import nvmp_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_ce,
  input wire logic i_we,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic [7:0] i_mask,
  output logic [7:0] o_rdata
);
  logic [7:0] mem_r [0:`NVMP_DEPTH-1];
  logic [7:0] merged;
  genvar b;
  generate
    for (b = 0; b < 8; b++) begin : g_bit
      // a mask bit of one leaves that cell unburnt
      assign merged[b] = i_mask[b] ? mem_r[i_addr][b] : i_wdata[b];
    end
  endgenerate
  // one writer for the whole array keeps a single driver on it
  always_ff @(posedge i_clk) begin
    if (i_ce && i_we) begin
      mem_r[i_addr] <= merged;
    end
  end
  always_ff @(posedge i_clk) begin
    if (i_ce) begin
      o_rdata <= mem_r[i_addr];
    end
  end
endmodule : nvmp_mem

// ### core/nvmp_ctrl.sv
// command decoder and program/read sequencer for the nonvolatile table
// assumes bytes arrive one per i_byte_valid, already deserialised
//
// Overview of operation
// RQ1: settings command BB, parameters with flag high
// RQ2: first parameter fields at fixed bit positions
// RQ3: mask bit one blocks that bit's programming
// RQ4: third parameter selects the table entry
// RQ5: programming only while write permit is one
// RQ6: program trigger burns selected register content
// RQ7: read trigger fetches selected entry back
// RQ8: sleep exit reloads registers from table
// RQ9: load disable bit skips that reload
// RQ10: host sets load disable while unprogrammed
// RQ11: host leaves reserved fields at defaults
// RQ12: settings command needs extended set unlocked
// RQ13: hardware reset clears every field to zero
// RQ14: software reset changes no field
// RQ15: unlock needs command plus exact key
// RQ16: triggers self-clear after their operation
`include "nvmp_cfg.svh"
module nvmp_ctrl
  import nvmp_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_byte_valid,
  input wire logic [7:0] i_byte,
  input wire logic i_data_command_select,
  input wire logic [7:0] i_reg_content,
  output nvmp_flags_t o_flags,
  output logic [7:0] o_mask,
  output logic [7:0] o_index,
  output logic o_read_trig,
  output logic o_unlocked,
  output nvmp_stat_t o_stat,
  output logic o_load_we,
  output logic [7:0] o_load_addr,
  output logic [7:0] o_load_data
);
  // ------------------------------------------------------------
  // command parsing
  // ------------------------------------------------------------
  nvmp_parse_t st_r;
  nvmp_op_t op_r;
  logic is_cmd, is_par;
  logic key_ok_r;
  logic prog_go, read_go, load_go;
  logic done;
  logic [`NVMP_CNT_W-1:0] cnt_r;
  logic [7:0] load_ptr_r;
  logic [7:0] mem_rdata;
  logic mem_we;
  logic [7:0] mem_addr;
  logic load_pend_r;

  assign is_cmd = i_ce && i_byte_valid && !i_data_command_select; // [RQ1]
  assign is_par = i_ce && i_byte_valid && i_data_command_select; // [RQ1]

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st_r <= NVMP_IDLE;
    end else if (is_cmd) begin
      if (i_byte == `NVMP_CMD_SETTINGS && o_unlocked) begin
        st_r <= NVMP_P1; // [RQ12]
      end else if (i_byte == `NVMP_CMD_UNLOCK) begin
        st_r <= NVMP_K1;
      end else begin
        st_r <= NVMP_IDLE;
      end
    end else if (is_par) begin
      case (st_r)
        NVMP_P1: st_r <= NVMP_P2;
        NVMP_P2: st_r <= NVMP_P3;
        NVMP_P3: st_r <= NVMP_P4;
        NVMP_K1: st_r <= NVMP_K2;
        NVMP_K2: st_r <= NVMP_K3;
        default: st_r <= NVMP_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // extended set unlock
  // ------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      key_ok_r <= 1'b0;
      o_unlocked <= 1'b0;
    end else if (is_par) begin
      case (st_r)
        NVMP_K1: key_ok_r <= (i_byte == `NVMP_KEY0); // [RQ15]
        NVMP_K2: key_ok_r <= key_ok_r && (i_byte == `NVMP_KEY1); // [RQ15]
        NVMP_K3: o_unlocked <= key_ok_r && (i_byte == `NVMP_KEY2); // [RQ15]
        default: key_ok_r <= key_ok_r;
      endcase
    end
  end

  // ------------------------------------------------------------
  // settings fields; software reset is just a command and touches none
  // ------------------------------------------------------------
  assign prog_go = is_par && st_r == NVMP_P1 && i_byte[`NVMP_BIT_PROG]
    && i_byte[`NVMP_BIT_WPERMIT] && op_r == NVMP_OP_IDLE; // [RQ5] [RQ6]
  assign read_go = is_par && st_r == NVMP_P4 && i_byte[`NVMP_BIT_READ]
    && op_r == NVMP_OP_IDLE; // [RQ7]

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_flags <= '{load_dis: 1'b0, charge: 1'b0, wpermit: 1'b0,
        test: `NVMP_RST_TEST, prog: 1'b0}; // [RQ13]
      o_mask <= `NVMP_RST_BYTE; // [RQ13]
      o_index <= `NVMP_RST_BYTE; // [RQ13]
      o_read_trig <= 1'b0; // [RQ13]
    end else if (i_ce) begin // [RQ14]
      if (is_par && st_r == NVMP_P1) begin
        o_flags.load_dis <= i_byte[`NVMP_BIT_LOAD_DIS]; // [RQ2]
        o_flags.charge <= i_byte[`NVMP_BIT_CHARGE]; // [RQ2]
        o_flags.wpermit <= i_byte[`NVMP_BIT_WPERMIT]; // [RQ2]
        o_flags.test <= i_byte[`NVMP_TEST_HI:`NVMP_TEST_LO]; // [RQ2]
        // a trigger written while busy is refused but must not cut a running burn
        o_flags.prog <= prog_go || (o_flags.prog && !(done && op_r == NVMP_OP_PROG)); // [RQ5]
      end else if (done && op_r == NVMP_OP_PROG) begin
        o_flags.prog <= 1'b0; // [RQ16]
      end
      if (is_par && st_r == NVMP_P2) begin
        o_mask <= i_byte; // [RQ3]
      end
      if (is_par && st_r == NVMP_P3) begin
        o_index <= i_byte; // [RQ4]
      end
      if (read_go) begin
        o_read_trig <= 1'b1; // [RQ7]
      end else if (done && op_r == NVMP_OP_READ) begin
        o_read_trig <= 1'b0; // [RQ16]
      end
    end
  end

  // ------------------------------------------------------------
  // operation sequencer
  // ------------------------------------------------------------
  // a sleep exit during a program waits until the burn ends
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      load_pend_r <= 1'b0;
    end else if (i_ce) begin
      if (is_cmd && i_byte == `NVMP_CMD_SLEEP_EXIT && !o_flags.load_dis) begin
        load_pend_r <= 1'b1; // [RQ8] [RQ9]
      end else if (load_go) begin
        load_pend_r <= 1'b0;
      end
    end
  end
  assign load_go = load_pend_r && op_r == NVMP_OP_IDLE;
  assign done = (op_r == NVMP_OP_PROG && cnt_r == `NVMP_CNT_W'(`NVMP_PROG_CYC - 1))
    || (op_r == NVMP_OP_READ && cnt_r == `NVMP_CNT_W'(`NVMP_READ_CYC - 1))
    || (op_r == NVMP_OP_LOAD && load_ptr_r == 8'hFF && cnt_r == `NVMP_CNT_W'(1));

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      op_r <= NVMP_OP_IDLE;
      cnt_r <= '0;
      load_ptr_r <= 8'h00;
    end else if (i_ce) begin
      case (op_r)
        NVMP_OP_IDLE: begin
          cnt_r <= '0;
          load_ptr_r <= 8'h00;
          if (prog_go) begin
            op_r <= NVMP_OP_PROG;
          end else if (read_go) begin
            op_r <= NVMP_OP_READ;
          end else if (load_go) begin
            op_r <= NVMP_OP_LOAD;
          end
        end
        NVMP_OP_LOAD: begin
          // one cycle to address, one to capture each entry
          cnt_r <= (cnt_r == `NVMP_CNT_W'(1)) ? '0 : cnt_r + `NVMP_CNT_W'(1);
          if (cnt_r == `NVMP_CNT_W'(1)) begin
            load_ptr_r <= load_ptr_r + 8'h01;
          end
          if (done) begin
            op_r <= NVMP_OP_IDLE;
          end
        end
        default: begin
          cnt_r <= cnt_r + `NVMP_CNT_W'(1);
          if (done) begin
            op_r <= NVMP_OP_IDLE;
          end
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // table access and outputs
  // ------------------------------------------------------------
  assign mem_we = op_r == NVMP_OP_PROG && cnt_r == '0 && o_flags.wpermit; // [RQ5] [RQ6]
  assign mem_addr = (op_r == NVMP_OP_LOAD) ? load_ptr_r : o_index; // [RQ4]

  nvmp_mem u_mem (
    .i_clk(i_clk),
    .i_ce(i_ce),
    .i_we(mem_we),
    .i_addr(mem_addr),
    .i_wdata(i_reg_content),
    .i_mask(o_mask),
    .o_rdata(mem_rdata)
  ); // [RQ3]

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_stat <= '0;
      o_load_we <= 1'b0;
      o_load_addr <= 8'h00;
      o_load_data <= 8'h00;
    end else if (i_ce) begin
      o_stat.busy <= (op_r != NVMP_OP_IDLE && !done) || prog_go || read_go || load_go;
      o_load_we <= op_r == NVMP_OP_LOAD && cnt_r == `NVMP_CNT_W'(1); // [RQ8]
      o_load_addr <= load_ptr_r;
      o_load_data <= mem_rdata;
      if (read_go) begin
        o_stat.rd_valid <= 1'b0;
      end else if (done && op_r == NVMP_OP_READ) begin
        o_stat.rd_valid <= 1'b1; // [RQ7]
        o_stat.rd_data <= mem_rdata;
      end
    end
  end
endmodule : nvmp_ctrl

// ### testbench/nvmp_checker.sv
// port assertions for the nvm command decoder
// bound to nvmp_ctrl from the bench top file
module nvmp_checker
  import nvmp_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_byte_valid,
  input wire logic [7:0] i_byte,
  input wire logic i_data_command_select,
  input wire nvmp_flags_t o_flags,
  input wire logic [7:0] o_mask,
  input wire logic [7:0] o_index,
  input wire logic o_read_trig,
  input wire logic o_unlocked,
  input wire nvmp_stat_t o_stat,
  input wire logic o_load_we,
  input wire logic [7:0] o_load_addr
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  sequence s_p1;
    i_byte_valid && !i_data_command_select && i_byte == 8'hBB && !o_stat.busy
    ##1 i_byte_valid && i_data_command_select;
  endsequence
  a_prog_permit: assert property ($rose(o_flags.prog) |-> o_flags.wpermit)
    else $error("program began without permit");
  a_prog_clear: assert property ($rose(o_flags.prog) |-> ##249 o_flags.prog ##1 !o_flags.prog)
    else $error("program trigger length wrong");
  a_read_done: assert property ($rose(o_read_trig) |-> ##[1:6] $rose(o_stat.rd_valid) && !o_read_trig)
    else $error("read did not finish");
  a_locked_hold: assert property (!o_unlocked ##0 s_p1 |=> $stable(o_flags))
    else $error("settings taken while locked");
  a_p1_fields: assert property (o_unlocked ##0 s_p1 |=> o_flags.load_dis == $past(i_byte[7]) && o_flags.wpermit == $past(i_byte[4]))
    else $error("first parameter fields misplaced");
  a_sw_keep: assert property (i_byte_valid && !i_data_command_select && i_byte == 8'h01 |=> $stable(o_mask) && $stable(o_index))
    else $error("software reset changed settings");
  a_load_step: assert property (o_load_we && o_load_addr != 8'hFF |-> ##2 o_load_we && o_load_addr == $past(o_load_addr, 2) + 8'h01)
    else $error("reload order broken");
  a_reset_zero: assert property (disable iff (1'b0) i_rst |=> o_mask == 8'h00 && o_index == 8'h00 && o_flags == 7'h00)
    else $error("reset left a field set");
endmodule : nvmp_checker

// ### testbench/nvmp_host.sv
// host model: sends command and parameter bytes to the decoder
// assumes the bench calls its tasks from one process
`include "nvmp_cfg.svh"
module nvmp_host (
  input wire logic i_clk,
  output logic o_valid,
  output logic [7:0] o_byte,
  output logic o_dcs
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    o_valid = 1'b0;
    o_byte = 8'h00;
    o_dcs = 1'b0;
  end
  // idle lines show the inverse so a stale byte never looks valid
  task automatic frame(input logic [7:0] c, input int n, input logic [31:0] p);
    @(posedge i_clk);
    o_valid <= 1'b1;
    o_dcs <= 1'b0;
    o_byte <= c;
    for (int k = 0; k < n; k++) begin
      @(posedge i_clk);
      o_dcs <= 1'b1;
      o_byte <= p[31 - 8 * k -: 8];
    end
    @(posedge i_clk);
    o_valid <= 1'b0;
    o_dcs <= ~o_dcs;
    o_byte <= ~o_byte;
  endtask : frame
  task automatic unlock();
    frame(`NVMP_CMD_UNLOCK, 3, {`NVMP_KEY0, `NVMP_KEY1, `NVMP_KEY2, 8'h00});
  endtask : unlock
endmodule : nvmp_host

// ### testbench/nvmp_ctrl_tb.sv
// self-checking bench for the nvm command decoder
// assumes nvmp_pkg compiled first, nvmp_cfg.svh on the include path
`include "nvmp_cfg.svh"
module nvmp_ctrl_tb
  import nvmp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_ce = 1'b1;
  logic [7:0] i_reg_content = 8'h00;
  logic vld, dcs, o_read_trig, o_unlocked, o_load_we;
  logic [7:0] byt, ld_seen, o_mask, o_index, o_load_addr, o_load_data;
  nvmp_flags_t o_flags;
  nvmp_stat_t o_stat;
  int failures = 0;
  int cmp_count = 0;
  int cyc = 0;
  int loads = 0;
  initial forever #20 i_clk = ~i_clk;
  nvmp_host host (.i_clk(i_clk), .o_valid(vld), .o_byte(byt), .o_dcs(dcs));
  nvmp_ctrl uut (.i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce), .i_byte_valid(vld),
    .i_byte(byt), .i_data_command_select(dcs), .i_reg_content(i_reg_content),
    .o_flags(o_flags), .o_mask(o_mask), .o_index(o_index), .o_read_trig(o_read_trig),
    .o_unlocked(o_unlocked), .o_stat(o_stat), .o_load_we(o_load_we),
    .o_load_addr(o_load_addr), .o_load_data(o_load_data));
  task automatic chk(input string nm, input logic [9:0] seen, input logic [9:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic summarize();
    $display("checks %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : summarize
  task automatic hw_reset();
    @(posedge i_clk);
    i_rst <= 1'b1;
    repeat (20) @(posedge i_clk);
    i_rst <= 1'b0;
    @(negedge i_clk);
    chk("mask", o_mask, 8'h00);
    chk("index", o_index, 8'h00);
    chk("flags", o_flags, 7'h00);
  endtask : hw_reset
  task automatic burn(input logic [7:0] v);
    @(posedge i_clk);
    i_reg_content <= v;
    host.frame(8'hBB, 1, 32'h1100_0000);
    @(negedge i_clk);
    chk("prog", o_flags.prog, 1'b1);
    repeat (300) if (o_stat.busy !== 1'b0) @(negedge i_clk);
    chk("prog end", {o_stat.busy, o_flags.prog}, 2'b00);
  endtask : burn
  // sampled at the falling edge so the design's updates have landed
  always @(negedge i_clk) begin
    cyc++;
    if (o_load_we === 1'b1) begin
      if (loads == 0) chk("first load", o_load_addr, 8'h00);
      if (o_load_addr === 8'h3C) ld_seen = o_load_data;
      loads++;
    end
    if (cyc == 8000) begin
      failures++;
      summarize();
    end
  end
  initial begin
    hw_reset();
    host.frame(8'hBB, 1, 32'h9100_0000);
    @(negedge i_clk);
    chk("locked flags", o_flags, 7'h00);
    host.frame(`NVMP_CMD_UNLOCK, 3, {`NVMP_KEY0, `NVMP_KEY1, 16'h0000});
    @(negedge i_clk);
    chk("bad key", o_unlocked, 1'b0);
    host.unlock();
    @(negedge i_clk);
    chk("unlocked", o_unlocked, 1'b1);
    $display("test unlock done");
    host.frame(8'hBB, 3, 32'h80F0_3C00);
    @(negedge i_clk);
    chk("flags", o_flags, 7'h40);
    chk("mask", o_mask, 8'hF0);
    chk("index", o_index, 8'h3C);
    host.frame(`NVMP_CMD_SLEEP_EXIT, 0, 32'h0);
    repeat (560) @(negedge i_clk);
    chk("no reload", 10'(loads), 10'd0);
    host.frame(8'hBB, 1, 32'h0100_0000);
    @(negedge i_clk);
    chk("no permit", {o_stat.busy, o_flags.prog}, 2'b00);
    $display("test fields done");
    host.frame(8'hBB, 3, 32'h0000_3C00);
    burn(8'hAA);
    host.frame(8'hBB, 3, 32'h00F0_3C00);
    burn(8'h55);
    host.frame(8'hBB, 4, 32'h10F0_3C01);
    repeat (10) if (o_stat.rd_valid !== 1'b1) @(negedge i_clk);
    chk("read", o_stat.rd_data, 8'hA5);
    chk("read trig", o_read_trig, 1'b0);
    $display("test program done");
    host.frame(`NVMP_CMD_SW_RESET, 0, 32'h0);
    @(negedge i_clk);
    chk("sw mask", o_mask, 8'hF0);
    chk("sw index", o_index, 8'h3C);
    // bytes offered while the clock enable is low must leave every field alone
    @(posedge i_clk);
    i_ce <= 1'b0;
    host.frame(8'hBB, 2, 32'h1000_0000);
    @(posedge i_clk);
    i_ce <= 1'b1;
    @(negedge i_clk);
    chk("frozen mask", o_mask, 8'hF0);
    host.frame(`NVMP_CMD_SLEEP_EXIT, 0, 32'h0);
    repeat (560) @(negedge i_clk);
    chk("reload count", 10'(loads), 10'd256);
    chk("reload entry", ld_seen, 8'hA5);
    hw_reset();
    $display("test reload done");
    summarize();
  end
endmodule : nvmp_ctrl_tb
bind nvmp_ctrl nvmp_checker chk_i (.i_clk(i_clk), .i_rst(i_rst), .i_byte_valid(i_byte_valid),
  .i_byte(i_byte), .i_data_command_select(i_data_command_select), .o_flags(o_flags),
  .o_mask(o_mask), .o_index(o_index), .o_read_trig(o_read_trig), .o_unlocked(o_unlocked),
  .o_stat(o_stat), .o_load_we(o_load_we), .o_load_addr(o_load_addr));
